// ==== hdl/clk_strap_decoder.sv ====
`timescale 1ns/1ps
module clk_strap_decoder
    import clk_strap_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // board strap
    input wire logic [STRAP_W-1:0] clk_ratio_strap,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // decoded clocking
    output clk_mode_e clk_mode,
    output logic [MULT_W-1:0] ref_mem_x2,
    output logic [MULT_W-1:0] mem_core_x2,
    output logic periph_pll_en,
    output logic core_pll_en,
    output logic proc_from_ref,
    output logic core_from_osc,
    output logic clocks_off,
    output logic cfg_valid
);

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // used for both the read path and the captured write phase
    function automatic reg_sel_e decode_addr(input logic [31:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr == READBACK_ADDR)
            sel = SEL_READBACK;
        else if (addr == STATUS_ADDR)
            sel = SEL_STATUS;
        else if (addr == CTRL_ADDR)
            sel = SEL_CTRL;
        else
            sel = SEL_NONE;
        return sel;
    endfunction : decode_addr

    phase_e phase_q, phase_d;
    logic [STRAP_W-1:0] strap_q, strap_d;
    ratio_entry_s entry;
    clk_mode_e mode_q, mode_d;
    logic [MULT_W-1:0] ref_q, ref_d, core_q, core_d;
    logic pll_p_q, pll_p_d, pll_c_q, pll_c_d;
    logic from_ref_q, from_ref_d, from_osc_q, from_osc_d;
    logic off_q, off_d, valid_q, valid_d;
    logic force_off_q, force_off_d;
    bus_req_s req_q, req_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, resp_q;
    logic take;
    logic [31:0] status_word;

    // ------------------------------------------------------------
    // strap capture sequence
    // ------------------------------------------------------------
    // strap is caught by a clocked edge after release, never by the reset
    always_comb
    begin
        phase_d = phase_q;
        strap_d = strap_q;
        case (phase_q)
            PH_SAMPLE:
            begin
                strap_d = clk_ratio_strap; // R8
                phase_d = PH_LOOKUP;
            end
            PH_LOOKUP: phase_d = PH_APPLY;
            PH_APPLY: phase_d = PH_RUN;
            PH_RUN: phase_d = PH_RUN; // R8
            default: phase_d = PH_SAMPLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= PH_SAMPLE;
            strap_q <= '0;
        end
        else
        begin
            phase_q <= phase_d;
            strap_q <= strap_d;
        end
    end

    // table lookup takes one cycle, hence the lookup phase
    ratio_rom u_rom (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .code(strap_q),
        .entry_q(entry)
    );

    // ------------------------------------------------------------
    // decoded clocking outputs
    // ------------------------------------------------------------
    // mode and ratios load once; only the software clock stop acts later
    always_comb
    begin
        mode_d = mode_q;
        ref_d = ref_q;
        core_d = core_q;
        pll_p_d = pll_p_q;
        pll_c_d = pll_c_q;
        from_ref_d = from_ref_q;
        from_osc_d = from_osc_q;
        off_d = off_q;
        valid_d = valid_q;
        if (phase_q == PH_APPLY)
        begin
            mode_d = entry.mode; // R8
            ref_d = entry.ref_mem_x2; // R7
            core_d = entry.mem_core_x2; // R7
            valid_d = 1'b1;
            pll_p_d = 1'b0;
            pll_c_d = 1'b0;
            from_ref_d = 1'b0;
            from_osc_d = 1'b0;
            off_d = 1'b1;
            case (entry.mode)
                MODE_PLL:
                begin
                    pll_p_d = 1'b1;
                    pll_c_d = 1'b1;
                    off_d = 1'b0;
                end
                MODE_PLL_BYPASS:
                begin
                    from_ref_d = 1'b1; // R4
                    pll_c_d = 1'b0; // R4
                    off_d = 1'b0;
                end
                MODE_DUAL_BYPASS:
                begin
                    from_osc_d = 1'b1; // R5
                    off_d = 1'b0;
                end
                default: off_d = 1'b1; // R3
            endcase
        end
        // software stop forces clocks_off and drops both pll enables until cleared
        if (phase_q == PH_RUN)
        begin
            off_d = force_off_q || (mode_q != MODE_PLL && mode_q != MODE_PLL_BYPASS
                && mode_q != MODE_DUAL_BYPASS); // R3
            pll_p_d = !force_off_q && (mode_q == MODE_PLL);
            pll_c_d = !force_off_q && (mode_q == MODE_PLL);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_q <= MODE_RESERVED;
            ref_q <= MULT_NONE;
            core_q <= MULT_NONE;
            pll_p_q <= 1'b0;
            pll_c_q <= 1'b0;
            from_ref_q <= 1'b0;
            from_osc_q <= 1'b0;
            off_q <= 1'b1;
            valid_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            ref_q <= ref_d;
            core_q <= core_d;
            pll_p_q <= pll_p_d;
            pll_c_q <= pll_c_d;
            from_ref_q <= from_ref_d;
            from_osc_q <= from_osc_d;
            off_q <= off_d;
            valid_q <= valid_d;
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    // zero wait states: read data is registered at the address edge
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    assign status_word = {18'h0, off_q, valid_q, core_q, ref_q, 1'b0, mode_q};

    always_comb
    begin
        req_d = '{1'b0, 1'b0, SEL_NONE};
        rdata_d = 32'h0000_0000;
        force_off_d = force_off_q;
        if (take)
        begin
            req_d = '{1'b1, hwrite, decode_addr(haddr)};
            if (!hwrite)
            begin
                if (decode_addr(haddr) == SEL_READBACK)
                    rdata_d[RB_LSB +: STRAP_W] = strap_q; // R1
                else if (decode_addr(haddr) == SEL_STATUS)
                    rdata_d = status_word;
                else if (decode_addr(haddr) == SEL_CTRL)
                    rdata_d[CTRL_FORCE_OFF_BIT] = force_off_q;
                else
                    rdata_d = 32'h0000_0000;
            end
        end
        // data phase of a write; readback and status ignore writes
        if (req_q.valid && req_q.write && req_q.sel == SEL_CTRL)
            force_off_d = hwdata[CTRL_FORCE_OFF_BIT];
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_q <= '{1'b0, 1'b0, SEL_NONE};
            rdata_q <= 32'h0000_0000;
            force_off_q <= CTRL_FORCE_OFF_RST;
            ready_q <= 1'b0;
            resp_q <= HRESP_OKAY;
        end
        else
        begin
            req_q <= req_d;
            rdata_q <= rdata_d;
            force_off_q <= force_off_d;
            ready_q <= 1'b1;
            resp_q <= HRESP_OKAY;
        end
    end

    // output drive, all straight from flops
    assign hreadyout = ready_q;
    assign hresp = resp_q;
    assign hrdata = rdata_q;
    assign clk_mode = mode_q;
    assign ref_mem_x2 = ref_q;
    assign mem_core_x2 = core_q;
    assign periph_pll_en = pll_p_q;
    assign core_pll_en = pll_c_q;
    assign proc_from_ref = from_ref_q;
    assign core_from_osc = from_osc_q;
    assign clocks_off = off_q;
    assign cfg_valid = valid_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    strap_hold_a: assert property ( // R8
        phase_q == PH_RUN |=> $stable(strap_q) && $stable(mode_q) && $stable(ref_q) && $stable(core_q))
        else $error("strap or decoded ratios changed after start");

    // reset is checked as sampled too: at the release edge the disable sees it high already
    settle_time_a: assert property ( // R8
        arst_n && phase_q == PH_SAMPLE |-> ##3 (phase_q == PH_RUN && valid_q))
        else $error("configuration not applied three cycles after sampling");

    readback_a: assert property ( // R1
        take && !hwrite && haddr == READBACK_ADDR |=> hrdata[RB_LSB +: STRAP_W] == strap_q && hrdata[2:0] == 3'h0)
        else $error("readback does not show sampled strap");

    clock_off_a: assert property ( // R3
        phase_q == PH_RUN && (strap_q == CODE_OFF_A || strap_q == CODE_OFF_B)
        |=> clocks_off && !periph_pll_en && !core_pll_en)
        else $error("clock-off code left clocks running");

    bypass_a: assert property ( // R4
        valid_q && mode_q == MODE_PLL_BYPASS
        |-> proc_from_ref && !periph_pll_en && ref_mem_x2 == MULT_X1 && !core_from_osc)
        else $error("pll bypass outputs wrong");

    dual_bypass_a: assert property ( // R5
        valid_q && mode_q == MODE_DUAL_BYPASS
        |-> core_from_osc && !periph_pll_en && !core_pll_en && ref_mem_x2 == MULT_X1 && mem_core_x2 == MULT_X1)
        else $error("dual bypass outputs wrong");

    ratio_zero_a: assert property ( // R7
        phase_q == PH_RUN && strap_q == 5'h00 |-> ref_mem_x2 == MULT_X3 && mem_core_x2 == MULT_X2_5)
        else $error("code zero ratios wrong");

    ratio_four_a: assert property ( // R7
        phase_q == PH_RUN && strap_q == 5'h04 |-> ref_mem_x2 == MULT_X2 && mem_core_x2 == MULT_X2)
        else $error("code four ratios wrong");

    pll_run_c: cover property (phase_q == PH_RUN && mode_q == MODE_PLL && !clocks_off);
    bypass_run_c: cover property (phase_q == PH_RUN && mode_q == MODE_PLL_BYPASS);
    clock_off_c: cover property (phase_q == PH_RUN && mode_q == MODE_CLOCK_OFF);
    force_off_c: cover property (mode_q == MODE_PLL && $rose(force_off_q));

endmodule : clk_strap_decoder

// ==== hdl/clk_strap_pkg.sv ====
// How it works
// R1: sampled five-bit strap reads back in the readback register, top bit at bit 7.
// R2: board drives only listed strap codes; unlisted codes are reserved.
// R3: codes 11110 and 11111 stop all internal clocking, whatever the reference does.
// R4: pll bypass clocks processor from reference, peripheral pll off, ratio 1:1.
// R5: dual bypass: peripheral from reference 1:1, core from oscillator 1:1, both plls off.
// R6: board keeps reference and core oscillator synchronised in dual bypass.
// R7: each valid code applies a reference-to-memory and memory-to-core multiplier.
// R8: strap sampled at reset release; decoded ratios and mode held until next reset.
package clk_strap_pkg;

    // ------------------------------------------------------------
    // widths and register map
    // ------------------------------------------------------------
    localparam int STRAP_W = 5;
    localparam int MULT_W = 4;
    localparam logic [31:0] READBACK_IDX = 32'h0000_00E2;
    localparam logic [31:0] READBACK_ADDR = READBACK_IDX << 2;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0000;
    localparam logic [31:0] CTRL_ADDR = 32'h0000_0004;

    // field positions
    localparam int RB_LSB = 3;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_REF_LSB = 4;
    localparam int ST_CORE_LSB = 8;
    localparam int ST_VALID_BIT = 12;
    localparam int ST_OFF_BIT = 13;
    localparam int CTRL_FORCE_OFF_BIT = 0;
    localparam logic CTRL_FORCE_OFF_RST = 1'b0;

    // ------------------------------------------------------------
    // strap codes and multipliers (in halves)
    // ------------------------------------------------------------
    localparam logic [STRAP_W-1:0] CODE_OFF_A = 5'h1E;
    localparam logic [STRAP_W-1:0] CODE_OFF_B = 5'h1F;
    localparam logic [STRAP_W-1:0] CODE_PLL_BYPASS = 5'h06;
    localparam logic [STRAP_W-1:0] CODE_DUAL_BYPASS = 5'h05;
    localparam logic [MULT_W-1:0] MULT_NONE = 4'h0;
    localparam logic [MULT_W-1:0] MULT_X1 = 4'h2;
    localparam logic [MULT_W-1:0] MULT_X2 = 4'h4;
    localparam logic [MULT_W-1:0] MULT_X2_5 = 4'h5;
    localparam logic [MULT_W-1:0] MULT_X3 = 4'h6;
    localparam logic [MULT_W-1:0] MULT_X4_5 = 4'h9;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_PLL = 3'b000,
        MODE_PLL_BYPASS = 3'b001,
        MODE_DUAL_BYPASS = 3'b010,
        MODE_CLOCK_OFF = 3'b011,
        MODE_RESERVED = 3'b100
    } clk_mode_e;

    typedef enum logic [1:0] {
        PH_SAMPLE = 2'b00,
        PH_LOOKUP = 2'b01,
        PH_APPLY = 2'b10,
        PH_RUN = 2'b11
    } phase_e;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_READBACK = 2'b01,
        SEL_STATUS = 2'b10,
        SEL_CTRL = 2'b11
    } reg_sel_e;

    typedef struct packed {
        clk_mode_e mode;
        logic [MULT_W-1:0] ref_mem_x2;
        logic [MULT_W-1:0] mem_core_x2;
    } ratio_entry_s;

    typedef struct packed {
        logic valid;
        logic write;
        reg_sel_e sel;
    } bus_req_s;

endpackage : clk_strap_pkg

// ==== hdl/ratio_rom.sv ====
`timescale 1ns/1ps
module ratio_rom
    import clk_strap_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // lookup
    input wire logic [STRAP_W-1:0] code,
    output ratio_entry_s entry_q
);

    ratio_entry_s entry_d;

    // ------------------------------------------------------------
    // strap code table
    // ------------------------------------------------------------
    // unlisted codes fall to reserved, which the top treats as clocks off
    always_comb
    begin
        entry_d = '{MODE_RESERVED, MULT_NONE, MULT_NONE};
        case (code)
            5'h00: entry_d = '{MODE_PLL, MULT_X3, MULT_X2_5}; // R7
            5'h01: entry_d = '{MODE_PLL, MULT_X3, MULT_X3}; // R7
            5'h02: entry_d = '{MODE_PLL, MULT_X1, MULT_X4_5}; // R7
            5'h03: entry_d = '{MODE_PLL, MULT_X1, MULT_X2}; // R7
            5'h04: entry_d = '{MODE_PLL, MULT_X2, MULT_X2}; // R7
            CODE_PLL_BYPASS: entry_d = '{MODE_PLL_BYPASS, MULT_X1, MULT_X1}; // R4
            CODE_DUAL_BYPASS: entry_d = '{MODE_DUAL_BYPASS, MULT_X1, MULT_X1}; // R5
            CODE_OFF_A, CODE_OFF_B: entry_d = '{MODE_CLOCK_OFF, MULT_NONE, MULT_NONE}; // R3
            default: entry_d = '{MODE_RESERVED, MULT_NONE, MULT_NONE};
        endcase
    end

    // registered read data
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            entry_q <= '{MODE_RESERVED, MULT_NONE, MULT_NONE};
        else
            entry_q <= entry_d;
    end

endmodule : ratio_rom

// ==== verification/strap_board_model.sv ====
`timescale 1ns/1ps
module strap_board_model
    import clk_strap_pkg::*;
(
    // reference
    input wire logic clk_sys,
    // requested strap
    input wire logic [STRAP_W-1:0] want_code,
    input wire logic allow_reserved,
    // board pins
    output logic [STRAP_W-1:0] clk_ratio_strap,
    output logic ref_clk,
    output logic core_oscillator_in
);
    // ------------------------------------------------------------
    // strap pins
    // ------------------------------------------------------------
    function automatic logic listed(input logic [STRAP_W-1:0] c);
        return (c <= 5'h06) || (c == CODE_OFF_A) || (c == CODE_OFF_B);
    endfunction : listed

    // unlisted codes fall back to code zero unless a test asks for one
    always_comb
    begin
        clk_ratio_strap = (listed(want_code) || allow_reserved) ? want_code : 5'h00;
    end

    // both clocks come from one source, so they never drift apart
    assign ref_clk = clk_sys;
    assign core_oscillator_in = clk_sys;
endmodule : strap_board_model

// ==== verification/pll_strap_clock_mode_decoder_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module pll_strap_clock_mode_decoder_tb_top
    import clk_strap_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] want_code = 5'h00;
    logic allow_reserved = 1'b0;
    logic [4:0] clk_ratio_strap;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout, hresp, periph_pll_en, core_pll_en, proc_from_ref, core_from_osc, clocks_off, cfg_valid;
    logic [31:0] hrdata, rd;
    clk_mode_e clk_mode;
    logic [3:0] ref_mem_x2, mem_core_x2;
    logic [31:0] seed = 32'h36ED;
    logic [4:0] tbl [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h1E, 5'h1F};
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    strap_board_model strap_board_model_i (.clk_sys(clk_sys), .want_code(want_code),
        .allow_reserved(allow_reserved), .clk_ratio_strap(clk_ratio_strap), .ref_clk(), .core_oscillator_in());
    clk_strap_decoder clk_strap_decoder_i (.clk_sys(clk_sys), .arst_n(arst_n), .clk_ratio_strap(clk_ratio_strap),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clk_mode(clk_mode),
        .ref_mem_x2(ref_mem_x2), .mem_core_x2(mem_core_x2), .periph_pll_en(periph_pll_en),
        .core_pll_en(core_pll_en), .proc_from_ref(proc_from_ref), .core_from_osc(core_from_osc),
        .clocks_off(clocks_off), .cfg_valid(cfg_valid));

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    function automatic ratio_entry_s exp_entry(input logic [4:0] c);
        case (c)
            5'h00: return '{MODE_PLL, MULT_X3, MULT_X2_5};
            5'h01: return '{MODE_PLL, MULT_X3, MULT_X3};
            5'h02: return '{MODE_PLL, MULT_X1, MULT_X4_5};
            5'h03: return '{MODE_PLL, MULT_X1, MULT_X2};
            5'h04: return '{MODE_PLL, MULT_X2, MULT_X2};
            5'h05: return '{MODE_DUAL_BYPASS, MULT_X1, MULT_X1};
            5'h06: return '{MODE_PLL_BYPASS, MULT_X1, MULT_X1};
            5'h1E, 5'h1F: return '{MODE_CLOCK_OFF, MULT_NONE, MULT_NONE};
            default: return '{MODE_RESERVED, MULT_NONE, MULT_NONE};
        endcase
    endfunction : exp_entry

    // periph pll, core pll, proc from ref, core from osc, clocks off
    function automatic logic [4:0] exp_flags(input clk_mode_e m);
        case (m)
            MODE_PLL: return 5'h18;
            MODE_PLL_BYPASS: return 5'h04;
            MODE_DUAL_BYPASS: return 5'h02;
            default: return 5'h01;
        endcase
    endfunction : exp_flags

    // ------------------------------------------------------------
    // bus and test tasks
    // ------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rdat);
        logic rdy;
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do
        begin
            @(negedge clk_sys);
            rdy = hreadyout;
            @(posedge clk_sys);
        end while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do
        begin
            @(negedge clk_sys);
            rdy = hreadyout;
            rdat = hrdata;
            @(posedge clk_sys);
        end while (rdy !== 1'b1);
    endtask : ahb

    task automatic run_code(input logic [4:0] c, input logic alw);
        ratio_entry_s e;
        logic [4:0] f;
        e = exp_entry(c);
        f = exp_flags(e.mode);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        want_code <= c;
        allow_reserved <= alw;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        `CHK("reset_state", 3'h4, {clocks_off, cfg_valid, hreadyout})
        @(posedge clk_sys);
        seed = xs(seed);
        // strap moves after the sampling edge and must be ignored
        want_code <= seed[4:0];
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("mode", e.mode, clk_mode)
        `CHK("ref_mult", e.ref_mem_x2, ref_mem_x2)
        `CHK("core_mult", e.mem_core_x2, mem_core_x2)
        `CHK("flags", f, {periph_pll_en, core_pll_en, proc_from_ref, core_from_osc, clocks_off})
        `CHK("valid", 1'b1, cfg_valid)
        ahb(1'b0, READBACK_ADDR, 32'h0, rd);
        `CHK("readback", {24'h0, c, 3'h0}, rd)
        ahb(1'b0, STATUS_ADDR, 32'h0, rd);
        `CHK("status", {18'h0, f[0], 1'b1, e.mem_core_x2, e.ref_mem_x2, 1'b0, e.mode}, rd)
        ahb(1'b1, READBACK_ADDR, seed, rd);
        ahb(1'b0, READBACK_ADDR, 32'h0, rd);
        `CHK("readback_ro", {24'h0, c, 3'h0}, rd)
        // read data stands for the data phase only, then drops back to zero
        @(negedge clk_sys);
        `CHK("rdata_idle", 32'h0, hrdata)
        ahb(1'b0, 32'h0000_0100, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        `CHK("hresp", HRESP_OKAY, hresp)
        $display("test strap %h done", c);
    endtask : run_code

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk_sys);
        foreach (tbl[i])
            run_code(tbl[i], 1'b0);
        run_code(5'h07, 1'b1);
        repeat (4)
        begin
            seed = xs(seed);
            run_code(seed[4:0], 1'b1);
        end
        // force-off overrides a running pll setup, then lets go again
        run_code(5'h00, 1'b0);
        ahb(1'b1, CTRL_ADDR, 32'h1, rd);
        @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("force_off", 3'h4, {clocks_off, periph_pll_en, core_pll_en})
        ahb(1'b0, CTRL_ADDR, 32'h0, rd);
        `CHK("ctrl", 1'b1, rd[0])
        ahb(1'b1, CTRL_ADDR, 32'h0, rd);
        @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("force_clear", 3'h3, {clocks_off, periph_pll_en, core_pll_en})
        $display("test force off done");
        final_report();
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            final_report();
        end
    end
endmodule : pll_strap_clock_mode_decoder_tb_top
